// ==== bench/sm_source_model.sv ====
`timescale 1ns/10ps
// ****************************************
// Far-side source model
// ****************************************
module sm_source_model
  import sm_pkg::*;
(
  // Bench commands
  input wire logic [4:0] modCode,
  input wire logic [4:0] hiCode,
  input wire logic [4:0] loCode,
  input wire logic modLevel,
  input wire logic hiLevel,
  input wire logic loLevel,
  // Source lines
  output logic [NUM_SOURCES-1:0] modSources,
  output logic [NUM_SOURCES-1:0] carHighSources,
  output logic [NUM_SOURCES-1:0] carLowSources
);
  // one line per code, others inverted
  always_comb begin
    for (int n = 0; n < NUM_SOURCES; n++) begin
      modSources[n] = (5'(n) == modCode) ? modLevel : ~modLevel;
      carHighSources[n] = (5'(n) == hiCode) ? hiLevel : ~hiLevel;
      carLowSources[n] = (5'(n) == loCode) ? loLevel : ~loLevel;
    end
  end
endmodule

// ==== bench/test_data_signal_modulator.sv ====
`timescale 1ns/10ps
module test_data_signal_modulator;
  import sm_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [NUM_SOURCES-1:0] modSources, carHighSources, carLowSources;
  logic streamValid, streamData;
  logic streamReady = 1'b1;
  logic modulatedOutputPin;
  logic modLevel = 1'b0;
  logic hiLevel = 1'b0;
  logic loLevel = 1'b0;
  int miscompares = 0;
  int testsRun = 0;

  always #12.5 clock = ~clock;

  sm_modulator u_sm_modulator (.clock(clock), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .modSources(modSources),
    .carHighSources(carHighSources), .carLowSources(carLowSources),
    .streamValid(streamValid), .streamData(streamData),
    .streamReady(streamReady), .modulatedOutputPin(modulatedOutputPin));

  sm_source_model u_sm_source_model (.modCode(5'h05), .hiCode(5'h07),
    .loCode(5'h09), .modLevel(modLevel), .hiLevel(hiLevel),
    .loLevel(loLevel), .modSources(modSources),
    .carHighSources(carHighSources), .carLowSources(carLowSources));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_bit(input string what, input logic e, input logic g);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic check_word(input string what, input logic [31:0] e,
                            input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, rd);
    check_word($sformatf("reg %h", a), e, rd);
  endtask

  task automatic levels(input logic m, input logic h, input logic l);
    modLevel <= m;
    hiLevel <= h;
    loLevel <= l;
    repeat (8) @(posedge clock);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic scen_reset;
    logic [7:0] regs [7] = '{ADDR_CONTROL_0, ADDR_CONTROL_1, ADDR_SOURCE,
      ADDR_CAR_HIGH, ADDR_CAR_LOW, ADDR_FIFO, ADDR_FIFO_STAT};
    check_bit("pin", 1'b0, modulatedOutputPin);
    check_bit("stream idle", 1'b0, streamValid);
    check_bit("hresp", 1'b0, hresp);
    foreach (regs[i]) rd_chk(regs[i], 32'h0);
    wr_reg(ADDR_FIFO, 32'hffffffff);
    rd_chk(ADDR_FIFO, 32'h0);
  endtask

  task automatic scen_mix;
    logic [2:0] v;
    wr_reg(ADDR_SOURCE, 32'h000000e5);
    rd_chk(ADDR_SOURCE, 32'h00000005);
    wr_reg(ADDR_CAR_HIGH, 32'h07);
    wr_reg(ADDR_CAR_LOW, 32'h09);
    wr_reg(ADDR_CONTROL_0, 32'h1 << POS_ENABLE);
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      levels(v[2], v[1], v[0]);
      check_bit("mix", v[2] ? v[1] : v[0], modulatedOutputPin);
    end
  endtask

  task automatic scen_disable;
    levels(1'b1, 1'b1, 1'b0);
    check_bit("enabled pin", 1'b1, modulatedOutputPin);
    wr_reg(ADDR_CONTROL_0, 32'h1 << POS_BIT);
    levels(1'b1, 1'b1, 1'b1);
    check_bit("disabled pin", 1'b0, modulatedOutputPin);
    rd_chk(ADDR_SOURCE, 32'h05);
    rd_chk(ADDR_CAR_HIGH, 32'h07);
    rd_chk(ADDR_CAR_LOW, 32'h09);
    wr_reg(ADDR_CONTROL_0, 32'h1 << POS_ENABLE);
    levels(1'b0, 1'b0, 1'b1);
    check_bit("reenabled pin", 1'b1, modulatedOutputPin);
  endtask

  task automatic scen_pol;
    logic [2:0] p;
    for (int i = 1; i < 8; i++) begin
      p = 3'(i);
      wr_reg(ADDR_CONTROL_1, (32'(p[2]) << POS_CH_INV) |
             (32'(p[1]) << POS_CL_INV));
      wr_reg(ADDR_CONTROL_0, (32'h1 << POS_ENABLE) |
             (32'(p[0]) << POS_OUT_INV));
      levels(1'b1, 1'b1, 1'b0);
      check_bit("pol high", ~p[2] ^ p[0], modulatedOutputPin);
      levels(1'b0, 1'b1, 1'b0);
      check_bit("pol low", p[1] ^ p[0], modulatedOutputPin);
    end
    wr_reg(ADDR_CONTROL_0, 32'h1 << POS_ENABLE);
  endtask

  task automatic scen_sync;
    wr_reg(ADDR_CONTROL_1, 32'h1 << POS_CH_SYNC);
    levels(1'b1, 1'b1, 1'b0);
    levels(1'b0, 1'b1, 1'b0);
    check_bit("high held", 1'b1, modulatedOutputPin);
    levels(1'b0, 1'b0, 1'b0);
    check_bit("high released", 1'b0, modulatedOutputPin);
    wr_reg(ADDR_CONTROL_1, 32'h1 << POS_CL_SYNC);
    levels(1'b0, 1'b0, 1'b1);
    levels(1'b1, 1'b0, 1'b1);
    check_bit("low held", 1'b1, modulatedOutputPin);
    levels(1'b1, 1'b0, 1'b0);
    check_bit("low released", 1'b0, modulatedOutputPin);
    wr_reg(ADDR_CONTROL_1, 32'h0);
    levels(1'b0, 1'b0, 1'b1);
    levels(1'b1, 1'b0, 1'b1);
    check_bit("unsynced switch", 1'b0, modulatedOutputPin);
  endtask

  task automatic scen_fifo;
    int cnt;
    int n;
    wr_reg(ADDR_FIFO_STAT, 32'h0);
    rd_chk(ADDR_FIFO_STAT, 32'h0);
    streamReady <= 1'b0;
    for (int i = 0; i < 20; i++) levels(1'b1, i[0] ? 1'b0 : 1'b1, 1'b0);
    rd_chk(ADDR_FIFO_STAT, 32'h30);
    check_bit("stream valid", 1'b1, streamValid);
    streamReady <= 1'b1;
    cnt = 0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (streamValid === 1'b1) begin
        check_bit("stream data", ~cnt[0], streamData);
        cnt++;
      end
    end while (streamValid === 1'b1 && n < 40);
    check_word("drained", 32'd16, 32'(cnt));
    rd_chk(ADDR_FIFO_STAT, 32'h20);
    wr_reg(ADDR_FIFO_STAT, 32'h0);
    rd_chk(ADDR_FIFO_STAT, 32'h0);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    scen_reset();
    scen_mix();
    scen_disable();
    scen_pol();
    scen_sync();
    scen_fifo();
    stop_test();
  end
endmodule

// ==== common/sm_pkg.sv ====
package sm_pkg;
  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CONTROL_0 = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_1 = 8'h04;
  localparam logic [7:0] ADDR_SOURCE = 8'h08;
  localparam logic [7:0] ADDR_CAR_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_CAR_LOW = 8'h10;
  localparam logic [7:0] ADDR_FIFO = 8'h14;
  localparam logic [7:0] ADDR_FIFO_STAT = 8'h18;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_ENABLE = 7;
  localparam int POS_OUT = 5;
  localparam int POS_OUT_INV = 4;
  localparam int POS_BIT = 0;
  localparam int POS_CH_INV = 5;
  localparam int POS_CH_SYNC = 4;
  localparam int POS_CL_INV = 1;
  localparam int POS_CL_SYNC = 0;
  localparam int SEL_WIDTH = 5;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [4:0] RESET_SELECT = 5'h00;
  // ****************************************
  // Source codes
  // ****************************************
  localparam logic [4:0] SEL_PIN = 5'h00;
  localparam logic [4:0] SEL_MOD_BIT = 5'h01;
  localparam logic [4:0] SEL_CAR_SYSCLK = 5'h01;
  localparam int NUM_SOURCES = 32;
  // ****************************************
  // Buffering
  // ****************************************
  localparam int FIFO_WIDTH = 1;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_PTR = 4;
  // ****************************************
  // Bus and sync state encodings
  // ****************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b00,
    SYNC_HIGH = 2'b01,
    SYNC_LOW = 2'b10
  } sm_sync_type;
endpackage

// ==== common/sm_stream_if.sv ====
`timescale 1ns/10ps
interface sm_stream_if;
  logic valid;
  logic ready;
  logic data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface

// ==== verilog/sm_fifo.sv ====
`timescale 1ns/10ps
module sm_fifo
  import sm_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int PTRW = FIFO_PTR
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Ports
  sm_stream_if.sink inPort,
  sm_stream_if.source outPort,
  // Status
  output logic [PTRW:0] level
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTRW-1:0] wrPtr_q;
  logic [PTRW-1:0] rdPtr_q;
  logic [PTRW:0] count_q;
  wire doWrite = inPort.valid && inPort.ready;
  wire doRead = outPort.valid && outPort.ready;
  assign inPort.ready = count_q < (PTRW+1)'(DEPTH);
  assign outPort.valid = count_q != '0;
  assign outPort.data = mem_q[rdPtr_q];
  assign level = count_q;
  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem_q[wrPtr_q] <= inPort.data;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + PTRW'(doWrite);
      rdPtr_q <= rdPtr_q + PTRW'(doRead);
      count_q <= count_q + (PTRW+1)'(doWrite) - (PTRW+1)'(doRead);
    end
  end
endmodule

// ==== verilog/sm_modulator.sv ====
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module sm_modulator
  import sm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Source inputs, one bit per select code
  input wire logic [NUM_SOURCES-1:0] modSources,
  input wire logic [NUM_SOURCES-1:0] carHighSources,
  input wire logic [NUM_SOURCES-1:0] carLowSources,
  // Captured output stream drain
  output logic streamValid,
  output logic streamData,
  input wire logic streamReady,
  // Modulated output pin
  output logic modulatedOutputPin
);
  // ****************************************
  // Registers
  // ****************************************
  logic enable_q;
  logic outInvert_q;
  logic modBit_q;
  logic chInvert_q;
  logic carrier_high_sync_en_q;
  logic clInvert_q;
  logic carrier_low_sync_en_q;
  logic [4:0] modSel_q;
  logic [4:0] chSel_q;
  logic [4:0] clSel_q;
  logic wrPend_q;
  logic rdPend_q;
  logic [7:0] addr_q;
  logic [31:0] rdData_q;
  sm_sync_type syncState_q;
  sm_sync_type syncState_d;
  logic chLast_q;
  logic clLast_q;
  logic mixed_q;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [NUM_SOURCES-1:0] modSync;
  logic [NUM_SOURCES-1:0] chSyncd;
  logic [NUM_SOURCES-1:0] clSyncd;
  sm_sync2 #(.WIDTH(NUM_SOURCES)) uModSync (
    .clock(clock), .reset(reset), .asyncIn(modSources), .syncOut(modSync));
  sm_sync2 #(.WIDTH(NUM_SOURCES)) uChSync (
    .clock(clock), .reset(reset), .asyncIn(carHighSources),
    .syncOut(chSyncd));
  sm_sync2 #(.WIDTH(NUM_SOURCES)) uClSync (
    .clock(clock), .reset(reset), .asyncIn(carLowSources),
    .syncOut(clSyncd));

  // ****************************************
  // Source selection
  // ****************************************
  // Disabled carriers fall back to pins
  wire [4:0] chSelEff = enable_q ? chSel_q : SEL_PIN;
  wire [4:0] clSelEff = enable_q ? clSel_q : SEL_PIN;
  wire [4:0] modSelEff = enable_q ? modSel_q : SEL_MOD_BIT;
  // Modulator mux, code 1 is the bit
  wire modRaw = (modSelEff == SEL_MOD_BIT) ? modBit_q : modSync[modSelEff];
  wire chRaw = chSyncd[chSelEff];
  wire clRaw = clSyncd[clSelEff];
  wire carrierHigh = chRaw ^ chInvert_q;
  wire carrierLow = clRaw ^ clInvert_q;
  wire chFall = chLast_q && !carrierHigh;
  wire clFall = clLast_q && !carrierLow;

  // ****************************************
  // Carrier synchronisation
  // ****************************************
  // Hold old carrier until its pulse ends
  always_comb begin
    syncState_d = syncState_q;
    case (syncState_q)
      SYNC_IDLE: syncState_d = modRaw ? SYNC_HIGH : SYNC_LOW;
      SYNC_HIGH: begin
        // High sync waits high falling edge
        if (!modRaw && (!carrier_high_sync_en_q || chFall || !carrierHigh)) begin
          syncState_d = SYNC_LOW;
        end
      end
      SYNC_LOW: begin
        // Low sync waits low falling edge
        if (modRaw && (!carrier_low_sync_en_q || clFall || !carrierLow)) begin
          syncState_d = SYNC_HIGH;
        end
      end
      default: syncState_d = SYNC_IDLE;
    endcase
  end
  wire useHigh = (syncState_q == SYNC_IDLE) ? modRaw :
    (syncState_q == SYNC_HIGH);
  wire activeCarrier = useHigh ? carrierHigh : carrierLow;
  // Active carrier, picked by modulator path
  wire mixedValue = activeCarrier;
  wire outValue = mixed_q ^ outInvert_q;

  always_ff @(posedge clock) begin
    if (reset || !enable_q) begin
      syncState_q <= SYNC_IDLE;
      chLast_q <= 1'b0;
      clLast_q <= 1'b0;
      mixed_q <= 1'b0;
    end else begin
      syncState_q <= syncState_d;
      chLast_q <= carrierHigh;
      clLast_q <= carrierLow;
      mixed_q <= mixedValue;
    end
  end

  // Drive pin only when enabled, else low
  always_ff @(posedge clock) begin
    if (reset) begin
      modulatedOutputPin <= 1'b0;
    end else begin
      modulatedOutputPin <= enable_q ? outValue : 1'b0;
    end
  end

  // ****************************************
  // Output capture FIFO
  // ****************************************
  sm_stream_if fifoIn();
  sm_stream_if fifoOut();
  logic [FIFO_PTR:0] fifoLevel;
  logic lastOut_q;
  assign fifoIn.valid = enable_q && (outValue != lastOut_q);
  assign fifoIn.data = outValue;
  assign fifoOut.ready = streamReady;
  assign streamValid = fifoOut.valid;
  assign streamData = fifoOut.data;
  wire fifoOverrun = fifoIn.valid && !fifoIn.ready;
  logic overrun_q;
  sm_fifo uFifo (
    .clock(clock), .reset(reset), .inPort(fifoIn), .outPort(fifoOut),
    .level(fifoLevel));
  always_ff @(posedge clock) begin
    if (reset) begin
      lastOut_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (fifoIn.valid && fifoIn.ready) begin
        lastOut_q <= outValue;
      end
      if (fifoOverrun) begin
        overrun_q <= 1'b1;
      end else if (wrPend_q && addr_q == ADDR_FIFO_STAT) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  wire addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData_q;
  wire [7:0] rdAddr = haddr[7:0];
  wire [7:0] ctrl0Read = {enable_q, 1'b0, modulatedOutputPin, outInvert_q,
    3'h0, modBit_q};
  wire [7:0] ctrl1Read = {2'h0, chInvert_q, carrier_high_sync_en_q, 2'h0, clInvert_q,
    carrier_low_sync_en_q};
  wire [31:0] readMux =
    (rdAddr == ADDR_CONTROL_0) ? {24'h0, ctrl0Read} :
    (rdAddr == ADDR_CONTROL_1) ? {24'h0, ctrl1Read} :
    (rdAddr == ADDR_SOURCE) ? {27'h0, modSel_q} :
    (rdAddr == ADDR_CAR_HIGH) ? {27'h0, chSel_q} :
    (rdAddr == ADDR_CAR_LOW) ? {27'h0, clSel_q} :
    (rdAddr == ADDR_FIFO_STAT) ? {26'h0, overrun_q, fifoLevel} :
    32'h0;

  always_ff @(posedge clock) begin
    if (reset) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q <= 8'h00;
      rdData_q <= 32'h0;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      rdPend_q <= addrPhase && !hwrite;
      addr_q <= addrPhase ? rdAddr : addr_q;
      rdData_q <= (addrPhase && !hwrite) ? readMux : 32'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      {enable_q, outInvert_q, modBit_q} <= 3'h0;
      {chInvert_q, carrier_high_sync_en_q, clInvert_q, carrier_low_sync_en_q} <= 4'h0;
      modSel_q <= RESET_SELECT;
      chSel_q <= RESET_SELECT;
      clSel_q <= RESET_SELECT;
    end else if (wrPend_q) begin
      case (addr_q)
        ADDR_CONTROL_0: begin
          enable_q <= hwdata[POS_ENABLE];
          outInvert_q <= hwdata[POS_OUT_INV];
          modBit_q <= hwdata[POS_BIT];
        end
        ADDR_CONTROL_1: begin
          chInvert_q <= hwdata[POS_CH_INV];
          carrier_high_sync_en_q <= hwdata[POS_CH_SYNC];
          clInvert_q <= hwdata[POS_CL_INV];
          carrier_low_sync_en_q <= hwdata[POS_CL_SYNC];
        end
        ADDR_SOURCE: modSel_q <= hwdata[4:0];
        ADDR_CAR_HIGH: chSel_q <= hwdata[4:0];
        ADDR_CAR_LOW: clSel_q <= hwdata[4:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_pin_low_disabled: assert property (@(posedge clock) disable iff (reset)
    !$past(enable_q) |-> !modulatedOutputPin)
    else $error("Pin not low while disabled");
  a_reset_defaults: assert property (@(posedge clock)
    $past(reset) && !reset |-> !enable_q && modSel_q == RESET_SELECT &&
    chSel_q == RESET_SELECT && clSel_q == RESET_SELECT)
    else $error("Reset defaults wrong");
  a_sync_idle_off: assert property (@(posedge clock) disable iff (reset)
    !$past(enable_q) |-> syncState_q == SYNC_IDLE)
    else $error("Sync not idle when disabled");
  a_select_kept: assert property (@(posedge clock) disable iff (reset)
    !$past(wrPend_q) |-> $stable(chSel_q) && $stable(modSel_q))
    else $error("Select changed without write");
  a_carrier_forced: assert property (@(posedge clock) disable iff (reset)
    !enable_q |-> chSelEff == SEL_PIN && clSelEff == SEL_PIN)
    else $error("Carrier not forced to pin");
  a_mod_forced: assert property (@(posedge clock) disable iff (reset)
    !enable_q |-> modRaw == modBit_q)
    else $error("Modulator not forced to bit");
  a_high_sync_hold: assert property (@(posedge clock) disable iff (reset)
    syncState_q == SYNC_HIGH && carrier_high_sync_en_q && carrierHigh && !chFall
    |=> syncState_q != SYNC_LOW)
    else $error("High carrier cut short");
  a_out_follows: assert property (@(posedge clock) disable iff (reset)
    enable_q && $past(enable_q) |->
    modulatedOutputPin == ($past(mixed_q) ^ $past(outInvert_q)))
    else $error("Output value mismatch");
endmodule

// ==== verilog/sm_sync2.sv ====
`timescale 1ns/10ps
module sm_sync2
  import sm_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      stage1_q <= '0;
      syncOut <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule
